// *** pkg/annp_consts.svh ***
// Offsets, field positions, reset values and counts for the expansion and next-page register block
`ifndef ANNP_CONSTS_SVH
`define ANNP_CONSTS_SVH
`define ANNP_IDX_EXP 8'h06
`define ANNP_IDX_NPT 8'h07
`define ANNP_IDX_STS 8'h10
`define ANNP_IDX_IRQ_ST 8'h20
`define ANNP_IDX_IRQ_MASK 8'h21
`define ANNP_EXP_PDF 4
`define ANNP_EXP_LPNP 3
`define ANNP_EXP_LNP 2
`define ANNP_EXP_PGRX 1
`define ANNP_EXP_LPAN 0
`define ANNP_NPT_MORE 15
`define ANNP_NPT_MSG 13
`define ANNP_NPT_COMPLY_ACKNOWLEDGE 12
`define ANNP_NPT_TOG 11
`define ANNP_STS_PGRX 8
`define ANNP_NPT_WMASK 16'hb7ff
`define ANNP_NPT_RST 16'h2001
`define ANNP_IRQ_W 3
`define ANNP_IRQ_PGRX 0
`define ANNP_IRQ_PDF 1
`define ANNP_IRQ_TOG 2
`endif

// *** pkg/annp_pkg.sv ***
// Types shared by the expansion and next-page register block
package annp_pkg;
	typedef struct packed {
		logic parallel_detect_fault;
		logic partner_nextpage_capable;
		logic partner_autoneg_capable;
		logic page_received;
		logic toggle_tx_bit;
	} annp_arb_in_t;
	typedef struct packed {
		logic more_pages_request;
		logic message_page_flag;
		logic comply_acknowledge;
		logic toggle_tx_bit;
		logic [10:0] code;
	} annp_np_word_t;
endpackage

// *** core/annp_regs.sv ***
// Auto-negotiation expansion status and next-page transmit registers behind a Wishbone slave
//
// Operation
// - reserved expansion bits 15:5 and next-page bit 14 read zero, writes ignored.
// - expansion bit 4 mirrors parallel detection fault; reset zero.
// - expansion bit 3 reports partner next-page capability; reset zero.
// - expansion bit 2 is a constant one: local next pages supported.
// - expansion bit 1 sets on page received, clears on expansion read.
// - expansion bit 0 reports partner auto-negotiation capability; reset zero.
// - next-page bit 15 requests further pages; software written, reset zero.
// - next-page bit 13 selects message or unformatted page; reset one.
// - next-page bit 12 is the comply acknowledge; reset zero.
// - next-page bit 11 read-only toggle from arbitration logic; reset zero.
// - next-page code field bits 10:0 resets to one, the null message.
// - expansion register at address 6, next-page register at address 7.
// - status bit 8 copies page-received; its read never clears it.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "annp_consts.svh"
module annp_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [1:0] wb_sel_i,
	input wire logic [15:0] wb_dat_i,
	output logic [15:0] wb_dat_o,
	output logic wb_ack_o,
	// Arbitration side, asynchronous to the bus clock
	input wire annp_pkg::annp_arb_in_t arb_i,
	output annp_pkg::annp_np_word_t np_word_o,
	// Interrupt
	output logic irq_o
);
	// Two-flop synchroniser for arbitration inputs
	annp_pkg::annp_arb_in_t arb_s1_r;
	annp_pkg::annp_arb_in_t arb_s2_r;
	logic page_d_r;
	logic pdf_d_r;
	logic tog_d_r;
	logic page_rx_r;
	logic page_rx_nxt;
	logic [15:0] npt_r;
	logic [15:0] npt_nxt;
	logic [`ANNP_IRQ_W-1:0] irq_st_r;
	logic [`ANNP_IRQ_W-1:0] irq_st_nxt;
	logic [`ANNP_IRQ_W-1:0] irq_mask_r;
	logic [`ANNP_IRQ_W-1:0] irq_ev;
	logic [15:0] rd_data;

	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] sel);
		lane_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction

	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire sel_exp = (wb_adr_i == `ANNP_IDX_EXP);
	wire sel_npt = (wb_adr_i == `ANNP_IDX_NPT);
	wire sel_sts = (wb_adr_i == `ANNP_IDX_STS);
	wire sel_ist = (wb_adr_i == `ANNP_IDX_IRQ_ST);
	wire sel_imk = (wb_adr_i == `ANNP_IDX_IRQ_MASK);
	wire rd_exp = req && !wb_we_i && sel_exp;
	wire wr_npt = req && wb_we_i && sel_npt;
	wire wr_ist = req && wb_we_i && sel_ist;
	wire wr_imk = req && wb_we_i && sel_imk;
	wire page_ev = arb_s2_r.page_received && !page_d_r;

	// Expansion word: reserved bits zero, bit 2 fixed one
	wire [15:0] exp_word = {11'h000, arb_s2_r.parallel_detect_fault,
		arb_s2_r.partner_nextpage_capable, 1'b1, page_rx_r,
		arb_s2_r.partner_autoneg_capable};
	wire [15:0] npt_word = {npt_r[15], 1'b0, npt_r[13:12], arb_s2_r.toggle_tx_bit, npt_r[10:0]};
	wire [15:0] sts_word = {7'h00, page_rx_r, 8'h00};

	always_comb begin
		if (sel_exp) begin
			rd_data = exp_word;
		end else if (sel_npt) begin
			rd_data = npt_word;
		end else if (sel_sts) begin
			rd_data = sts_word;
		end else if (sel_ist) begin
			rd_data = {13'h0000, irq_st_r};
		end else if (sel_imk) begin
			rd_data = {13'h0000, irq_mask_r};
		end else begin
			rd_data = 16'h0000;
		end
	end

	// Set wins over the read clear
	assign page_rx_nxt = page_ev ? 1'b1 : (rd_exp ? 1'b0 : page_rx_r);
	// Software bits only; bit 14 and toggle are not stored
	assign npt_nxt = wr_npt ? (lane_merge(npt_r, wb_dat_i, wb_sel_i) & `ANNP_NPT_WMASK) : npt_r;
	assign irq_ev = {tog_d_r ^ arb_s2_r.toggle_tx_bit, arb_s2_r.parallel_detect_fault && !pdf_d_r, page_ev};
	assign irq_st_nxt = irq_ev | (irq_st_r & ~((wr_ist && wb_sel_i[0]) ? wb_dat_i[`ANNP_IRQ_W-1:0] : 3'h0));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_s1_r <= '0;
			arb_s2_r <= '0;
			page_d_r <= 1'b0;
			pdf_d_r <= 1'b0;
			tog_d_r <= 1'b0;
		end else begin
			arb_s1_r <= arb_i;
			arb_s2_r <= arb_s1_r;
			page_d_r <= arb_s2_r.page_received;
			pdf_d_r <= arb_s2_r.parallel_detect_fault;
			tog_d_r <= arb_s2_r.toggle_tx_bit;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			page_rx_r <= 1'b0;
			npt_r <= `ANNP_NPT_RST;
			irq_st_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			page_rx_r <= page_rx_nxt;
			npt_r <= npt_nxt;
			irq_st_r <= irq_st_nxt;
			if (wr_imk && wb_sel_i[0]) begin
				irq_mask_r <= wb_dat_i[`ANNP_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 16'h0000;
			irq_o <= 1'b0;
			np_word_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_data : 16'h0000;
			irq_o <= |(irq_st_nxt & irq_mask_r);
			np_word_o <= {npt_nxt[15], npt_nxt[13], npt_nxt[12], arb_s2_r.toggle_tx_bit, npt_nxt[10:0]};
		end
	end

	// Checks
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_exp) |-> wb_dat_o[15:5] == 11'h000 && wb_dat_o[2]) else $error("expansion reserved bits");
	npt_bit14_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_npt) |-> !wb_dat_o[14]) else $error("next-page bit 14 not zero");
	pdf_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_exp) |-> wb_dat_o[4] == $past(arb_s2_r.parallel_detect_fault)) else $error("fault bit");
	lpnp_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_exp) |-> wb_dat_o[3] == $past(arb_s2_r.partner_nextpage_capable)) else $error("lp np bit");
	lpan_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_exp) |-> wb_dat_o[0] == $past(arb_s2_r.partner_autoneg_capable)) else $error("lp an bit");
	page_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_exp && !page_ev |=> !page_rx_r) else $error("page flag not cleared by read");
	page_set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		page_ev |=> page_rx_r) else $error("page event lost");
	sts_noclear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		req && !wb_we_i && sel_sts && page_rx_r |=> page_rx_r) else $error("status read cleared flag");
	npt_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_npt && wb_sel_i == 2'h3 |=> npt_r == (($past(wb_dat_i)) & `ANNP_NPT_WMASK)) else $error("next-page write");
	tog_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o && $past(sel_npt) |-> wb_dat_o[11] == $past(arb_s2_r.toggle_tx_bit)) else $error("toggle bit");
	ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	exp_read_cv: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_exp && page_rx_r);
	collide_cv: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_exp && page_ev);
	npt_write_cv: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_npt);
	irq_cv: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_o);
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the expansion and next-page register block
`timescale 1ns/1ps
`include "annp_consts.svh"
module tb;
	logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq;
	logic [7:0] adr = 0;
	logic [1:0] sel = 0;
	logic [15:0] di = 0, dout, d, e;
	logic [15:0] q[$];
	annp_pkg::annp_arb_in_t arb = '0;
	annp_pkg::annp_np_word_t npw;
	int fails = 0, samples_checked = 0, seed = 57192;
	annp_regs u_annp_regs (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .arb_i(arb),
		.np_word_o(npw), .irq_o(irq));
	initial forever #4 sys_clk = ~sys_clk;
	task chk(input logic [15:0] s, input logic [15:0] x);
		samples_checked++;
		if (s !== x) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task wrap_up;
		$display("checks=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One classic cycle; a read notes its expected data for the monitor
	task acc(input logic w, input logic [7:0] a, input logic [15:0] x, input logic [15:0] r);
		int n;
		n = 0;
		if (!w) q.push_back(r);
		{cyc, stb, we, adr, di, sel} <= {2'b11, w, a, x, 2'h3};
		@(posedge sys_clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		// A missing acknowledge counts against the run
		if (ack !== 1'b1) begin
			fails++;
			$display("MISMATCH t=%0t no ack at adr=%h", $time, a);
		end
		{cyc, stb} <= 2'b00;
		@(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] r);
		acc(1'b0, a, 16'h0000, r);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] x);
		acc(1'b1, a, x, 16'h0000);
	endtask
	// Arbitration inputs pass a two-flop synchroniser before they show
	task settle;
		repeat (6) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		if (ack === 1'b1 && we === 1'b0) chk(dout, q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(`ANNP_IDX_EXP, 16'h0004);
		rd(`ANNP_IDX_NPT, `ANNP_NPT_RST);
		chk({1'b0, npw}, 16'h2001);
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			arb <= $random(seed) & 5'h1d;
			d = $random(seed);
			settle;
			wr(`ANNP_IDX_EXP, d);
			rd(`ANNP_IDX_EXP, {11'h0, arb[4:3], 2'b10, arb[2]});
			wr(`ANNP_IDX_NPT, d);
			e = d & `ANNP_NPT_WMASK | {4'h0, arb[0], 11'h0};
			rd(`ANNP_IDX_NPT, e);
			chk({1'b0, npw}, {1'b0, e[15], e[13:0]});
		end
		wr(8'h33, d);
		rd(8'h33, 16'h0000);
		$display("random fields done");
		arb <= '0;
		settle;
		wr(`ANNP_IDX_IRQ_ST, 16'h0007);
		wr(`ANNP_IDX_IRQ_MASK, 16'h0001);
		rd(`ANNP_IDX_EXP, 16'h0004);
		rd(`ANNP_IDX_IRQ_ST, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		arb.page_received <= 1'b1;
		settle;
		chk({15'h0, irq}, 16'h0001);
		rd(`ANNP_IDX_STS, 16'h0100);
		rd(`ANNP_IDX_STS, 16'h0100);
		rd(`ANNP_IDX_EXP, 16'h0006);
		rd(`ANNP_IDX_EXP, 16'h0004);
		rd(`ANNP_IDX_STS, 16'h0000);
		rd(`ANNP_IDX_IRQ_ST, 16'h0001);
		wr(`ANNP_IDX_IRQ_MASK, 16'h0000);
		settle;
		chk({15'h0, irq}, 16'h0000);
		wr(`ANNP_IDX_IRQ_ST, 16'h0001);
		rd(`ANNP_IDX_IRQ_ST, 16'h0000);
		$display("page flag and interrupt done");
		wrap_up;
	end
endmodule
